// ==== hdl/branch_exec_defines.vh ====
// Purpose: Constants for the branch and pointer increment execution block
// Assumes: 8-bit core, 16-bit program counter and data pointer
// Notes: Opcode values are local to this block
`ifndef BRANCH_EXEC_DEFINES_VH
`define BRANCH_EXEC_DEFINES_VH

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_NONE 4'h0
`define OP_PTR_INC 4'h1
`define OP_JMP_BIT_SET 4'h2
`define OP_JMP_CLR_BIT 4'h3
`define OP_JMP_CARRY 4'h4
`define OP_JMP_NO_CARRY 4'h5
`define OP_JMP_INDIRECT 4'h6
`define OP_JMP_BIT_CLR 4'h7
`define OP_JMP_ACC_NZ 4'h8
`define OP_JMP_ACC_Z 4'h9
`define OP_LONG_CALL 4'ha

// ----------------------------------------
// Instruction lengths and reset values
// ----------------------------------------
`define LEN_TWO 16'h0002
`define LEN_THREE 16'h0003
`define RST_PC 16'h0000
`define RST_PTR 16'h0000
`define RST_SP 8'h07

`endif

// ==== hdl/rel_target.v ====
// Purpose: Relative branch target from an advanced program counter
// Assumes: Displacement is 8-bit two's complement
// Notes: Sum wraps modulo 65536
`timescale 1ns/1ps
module rel_target (
    input wire [15:0] pc_in,
    input wire [15:0] len_in,
    input wire [7:0] disp_in,
    input wire take_in,
    output wire [15:0] next_pc_out
);
    wire [15:0] advanced;
    wire [15:0] disp_ext;
    wire [15:0] taken;
    assign advanced = pc_in + len_in;
    assign disp_ext = {{8{disp_in[7]}}, disp_in};
    assign taken = advanced + disp_ext;
    assign next_pc_out = take_in ? taken : advanced;
endmodule // rel_target

// ==== hdl/wide_inc.v ====
// Purpose: 16-bit add of an 8-bit unsigned value with carry into high byte
// Assumes: Operands unsigned
// Notes: Used for pointer increment and indirect jump
`timescale 1ns/1ps
module wide_inc (
    input wire [15:0] base_in,
    input wire [7:0] add_in,
    output wire [15:0] sum_out
);
    wire [8:0] low_sum;
    wire [7:0] high_sum;
    // Low byte carry ripples into the high byte
    assign low_sum = {1'b0, base_in[7:0]} + {1'b0, add_in};
    assign high_sum = base_in[15:8] + {7'h00, low_sum[8]};
    assign sum_out = {high_sum, low_sum[7:0]};
endmodule // wide_inc

// ==== hdl/branch_and_pointer_increment_exec.v ====
// Purpose: Executes pointer increment, relative jumps, indirect jump, call
// Assumes: Decoder presents one operation with its operand bytes per pulse
// Notes: Bit values are read by the caller; port bits for jump-and-clear come from the latch
`timescale 1ns/1ps
`include "branch_exec_defines.vh"

// What this block does
// - Pointer increment adds one to the 16-bit pointer, carrying, no flags.
// - The data pointer has its own 16-bit increment path; pc adds one through a separate adder.
// - Bit-set jump advances three, branches by third byte when bit is one.
// - Jump-and-clear branches and clears a set bit; zero bit is not written.
// - Jump-and-clear on a port bit tests the output latch, not the pin.
// - Carry jump advances two, branches by second byte when carry set.
// - No-carry jump branches only when carry is zero; carry never changes.
// - Indirect jump loads accumulator plus pointer, wrapping, nothing altered.
// - Bit-clear jump advances three, branches by third byte when bit zero.
// - Nonzero jump advances two, branches when any accumulator bit is one.
// - Zero jump advances two, branches when accumulator is all zero.
// - Long call pushes pc plus three low byte first, stack rising two.
// - Long call then loads pc high from byte two, low from byte three.
module branch_and_pointer_increment_exec (
    input wire clk_in,
    input wire nrst_in,
    input wire start_in,
    input wire [3:0] op_in,
    input wire [7:0] byte2_in,
    input wire [7:0] byte3_in,
    input wire bit_value_in,
    input wire bit_is_port_in,
    input wire port_latch_bit_in,
    input wire carry_in,
    input wire [7:0] acc_in,
    input wire ptr_load_in,
    input wire [15:0] ptr_load_value_in,
    input wire sp_load_in,
    input wire [7:0] sp_load_value_in,
    output wire busy_out,
    output reg done_out,
    output reg [15:0] pc_out,
    output wire [7:0] pointer_low_byte_out,
    output wire [7:0] pointer_high_byte_out,
    output reg [7:0] stack_pointer_out,
    output reg ram_we_out,
    output reg [7:0] ram_addr_out,
    output reg [7:0] ram_wdata_out,
    output reg bit_clear_out
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_PUSH_LO = 2'd1;
    localparam ST_PUSH_HI = 2'd2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [15:0] data_pointer_q;
    reg [15:0] data_pointer_d;
    reg [15:0] pc_d;
    reg [7:0] sp_d;
    reg [15:0] ret_q;
    reg [15:0] ret_d;
    reg [15:0] call_dest_q;
    reg [15:0] call_dest_d;
    reg done_d;
    reg we_d;
    reg [7:0] waddr_d;
    reg [7:0] wdata_d;
    reg clr_d;

    // ----------------------------------------
    // Condition and length selection
    // ----------------------------------------
    reg take;
    reg [15:0] len;
    reg tested_bit;
    wire [15:0] rel_next;
    wire [15:0] ptr_plus_one;
    wire [15:0] indirect_dest;
    wire [15:0] ret_addr;

    function is_three_byte;
        input [3:0] op;
        begin
            is_three_byte = (op == `OP_JMP_BIT_SET) ||
                (op == `OP_JMP_CLR_BIT) || (op == `OP_JMP_BIT_CLR);
        end
    endfunction

    // Stack pre-increment wraps within the 8-bit internal space
    function [7:0] stack_next;
        input [7:0] sp;
        begin
            stack_next = sp + 8'h01;
        end
    endfunction

    // Jump-and-clear port bits test the latch: the pin may be held low from outside
    always @* begin
        tested_bit = bit_value_in;
        if (op_in == `OP_JMP_CLR_BIT && bit_is_port_in) begin
            tested_bit = port_latch_bit_in;
        end
        len = is_three_byte(op_in) ? `LEN_THREE : `LEN_TWO;
        case (op_in)
            `OP_JMP_BIT_SET: take = tested_bit;
            `OP_JMP_CLR_BIT: take = tested_bit;
            `OP_JMP_BIT_CLR: take = ~tested_bit;
            `OP_JMP_CARRY: take = carry_in;
            `OP_JMP_NO_CARRY: take = ~carry_in;
            `OP_JMP_ACC_NZ: take = |acc_in;
            `OP_JMP_ACC_Z: take = ~(|acc_in);
            default: take = 1'b0;
        endcase
    end

    rel_target u_rel (
        .pc_in(pc_out),
        .len_in(len),
        .disp_in(is_three_byte(op_in) ? byte3_in : byte2_in),
        .take_in(take),
        .next_pc_out(rel_next)
    );

    // 16-bit increment path owned by the pointer; pc increments through its own adder
    wide_inc u_ptr_inc (
        .base_in(data_pointer_q),
        .add_in(8'h01),
        .sum_out(ptr_plus_one)
    );

    wide_inc u_indirect (
        .base_in(data_pointer_q),
        .add_in(acc_in),
        .sum_out(indirect_dest)
    );

    assign ret_addr = pc_out + `LEN_THREE;

    // ----------------------------------------
    // Data pointer
    // ----------------------------------------
    // Increment beats a same-cycle external load
    always @* begin
        data_pointer_d = data_pointer_q;
        if (ptr_load_in) begin
            data_pointer_d = ptr_load_value_in;
        end
        if (start_in && state_q == ST_IDLE && op_in == `OP_PTR_INC) begin
            data_pointer_d = ptr_plus_one;
        end
    end

    // ----------------------------------------
    // Stack pointer
    // ----------------------------------------
    // A load during a push would tear the frame, so the push wins
    always @* begin
        sp_d = stack_pointer_out;
        if (sp_load_in) begin
            sp_d = sp_load_value_in;
        end
        if (state_q == ST_PUSH_LO || state_q == ST_PUSH_HI) begin
            sp_d = stack_next(stack_pointer_out);
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always @* begin
        state_d = state_q;
        pc_d = pc_out;
        ret_d = ret_q;
        call_dest_d = call_dest_q;
        done_d = 1'b0;
        we_d = 1'b0;
        waddr_d = ram_addr_out;
        wdata_d = ram_wdata_out;
        clr_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (start_in) begin
                    case (op_in)
                        `OP_PTR_INC: begin
                            pc_d = pc_out + 16'h0001;
                            done_d = 1'b1;
                        end
                        `OP_JMP_INDIRECT: begin
                            pc_d = indirect_dest;
                            done_d = 1'b1;
                        end
                        `OP_JMP_BIT_SET, `OP_JMP_BIT_CLR, `OP_JMP_CARRY,
                        `OP_JMP_NO_CARRY, `OP_JMP_ACC_NZ,
                        `OP_JMP_ACC_Z: begin
                            pc_d = rel_next;
                            done_d = 1'b1;
                        end
                        `OP_JMP_CLR_BIT: begin
                            pc_d = rel_next;
                            clr_d = take;
                            done_d = 1'b1;
                        end
                        `OP_LONG_CALL: begin
                            ret_d = ret_addr;
                            call_dest_d = {byte2_in, byte3_in};
                            state_d = ST_PUSH_LO;
                        end
                        default: begin
                            done_d = 1'b1;
                        end
                    endcase
                end
            end
            ST_PUSH_LO: begin
                // Pre-increment, then store low byte
                we_d = 1'b1;
                waddr_d = stack_next(stack_pointer_out);
                wdata_d = ret_q[7:0];
                state_d = ST_PUSH_HI;
            end
            ST_PUSH_HI: begin
                we_d = 1'b1;
                waddr_d = stack_next(stack_pointer_out);
                wdata_d = ret_q[15:8];
                pc_d = call_dest_q;
                done_d = 1'b1;
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Pointer and stack stay live in every state
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            data_pointer_q <= `RST_PTR;
            pc_out <= `RST_PC;
            stack_pointer_out <= `RST_SP;
        end else begin
            data_pointer_q <= data_pointer_d;
            pc_out <= pc_d;
            stack_pointer_out <= sp_d;
        end
    end

    // ----------------------------------------
    // Call sequencer
    // ----------------------------------------
    // Return address and target frozen so operand bytes may move on
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_IDLE;
            ret_q <= 16'h0000;
            call_dest_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            ret_q <= ret_d;
            call_dest_q <= call_dest_d;
        end
    end

    // ----------------------------------------
    // Stack write port
    // ----------------------------------------
    // Address and data hold between pushes for a slow RAM
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ram_we_out <= 1'b0;
            ram_addr_out <= 8'h00;
            ram_wdata_out <= 8'h00;
        end else begin
            ram_we_out <= we_d;
            ram_addr_out <= waddr_d;
            ram_wdata_out <= wdata_d;
        end
    end

    // ----------------------------------------
    // Completion pulses
    // ----------------------------------------
    // Bit write-back is left to the owner of the bit
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            done_out <= 1'b0;
            bit_clear_out <= 1'b0;
        end else begin
            done_out <= done_d;
            bit_clear_out <= clr_d;
        end
    end

    // Decoded from state, so a start is refused from the taking edge on
    assign busy_out = (state_q != ST_IDLE);
    assign pointer_low_byte_out = data_pointer_q[7:0];
    assign pointer_high_byte_out = data_pointer_q[15:8];

endmodule // branch_and_pointer_increment_exec

// ==== testbench/prog_mem_model.sv ====
// Purpose: Program memory stand-in supplying operand bytes
// Assumes: Combinational read, always selected
// Notes: Fill pattern is arbitrary but fixed
`timescale 1ns/1ps
module prog_mem_model (
    input wire [15:0] addr_in,
    output wire [7:0] data_out
);
    // Mixes both address bytes so displacements take both signs
    assign data_out = addr_in[7:0] ^ addr_in[15:8] ^ 8'h5a;
endmodule // prog_mem_model

// ==== testbench/branch_exec_monitor.sv ====
// Purpose: Port checks for the branch execution block
// Assumes: Single clock, async active-low reset
// Notes: Call operands captured at the taking edge
`timescale 1ns/1ps
`include "branch_exec_defines.vh"
module branch_exec_monitor (
    input wire clk_in,
    input wire nrst_in,
    input wire start_in,
    input wire [3:0] op_in,
    input wire [7:0] byte2_in,
    input wire [7:0] byte3_in,
    input wire bit_value_in,
    input wire bit_is_port_in,
    input wire port_latch_bit_in,
    input wire carry_in,
    input wire [7:0] acc_in,
    input wire ptr_load_in,
    input wire busy_out,
    input wire done_out,
    input wire [15:0] pc_out,
    input wire [7:0] pointer_low_byte_out,
    input wire [7:0] pointer_high_byte_out,
    input wire [7:0] stack_pointer_out,
    input wire ram_we_out,
    input wire [7:0] ram_addr_out,
    input wire [7:0] ram_wdata_out,
    input wire bit_clear_out
);
    wire tk = start_in && !busy_out;
    wire [15:0] dp = {pointer_high_byte_out, pointer_low_byte_out};
    wire [15:0] s2 = {{8{byte2_in[7]}}, byte2_in};
    wire [15:0] s3 = {{8{byte3_in[7]}}, byte3_in};
    wire jbit = bit_is_port_in ? port_latch_bit_in : bit_value_in;
    wire acc_tk = (op_in == `OP_JMP_ACC_NZ) == (acc_in != 8'h00);
    reg [15:0] ret_q;
    reg [15:0] tgt_q;
    reg [7:0] sp_q;
    always @(posedge clk_in) begin
        if (tk) begin
            ret_q <= pc_out + 16'h0003;
            tgt_q <= {byte2_in, byte3_in};
            sp_q <= stack_pointer_out;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    a_ptr_inc_wrap: assert property (tk && op_in == `OP_PTR_INC
        |=> dp == $past(dp) + 16'h0001) else $error("pointer increment");
    a_jb_target: assert property (tk && op_in == `OP_JMP_BIT_SET
        |=> pc_out == $past(pc_out) + 16'h0003
        + ($past(bit_value_in) ? $past(s3) : 16'h0)) else $error("jb");
    a_jbc_clear: assert property (tk && op_in == `OP_JMP_CLR_BIT
        |=> bit_clear_out == $past(jbit) && pc_out == $past(pc_out)
        + 16'h0003 + ($past(jbit) ? $past(s3) : 16'h0)) else $error("jbc");
    a_jc_target: assert property (tk && op_in == `OP_JMP_CARRY
        |=> pc_out == $past(pc_out) + 16'h0002
        + ($past(carry_in) ? $past(s2) : 16'h0)) else $error("jc");
    a_jnc_target: assert property (tk && op_in == `OP_JMP_NO_CARRY
        |=> pc_out == $past(pc_out) + 16'h0002
        + ($past(carry_in) ? 16'h0 : $past(s2))) else $error("jnc");
    a_indirect_sum: assert property (tk && op_in == `OP_JMP_INDIRECT
        && !ptr_load_in |=> pc_out == $past(dp) + {8'h00, $past(acc_in)}
        && $stable(dp)) else $error("indirect jump");
    a_jnb_target: assert property (tk && op_in == `OP_JMP_BIT_CLR
        |=> pc_out == $past(pc_out) + 16'h0003
        + ($past(bit_value_in) ? 16'h0 : $past(s3))) else $error("jnb");
    a_acc_jump: assert property (tk && (op_in == `OP_JMP_ACC_NZ
        || op_in == `OP_JMP_ACC_Z) |=> pc_out == $past(pc_out) + 16'h0002
        + ($past(acc_tk) ? $past(s2) : 16'h0)) else $error("acc jump");
    a_call_push: assert property (tk && op_in == `OP_LONG_CALL
        |-> ##2 ram_we_out && ram_addr_out == sp_q + 8'h01
        && ram_wdata_out == ret_q[7:0] ##1 ram_we_out
        && ram_addr_out == sp_q + 8'h02 && ram_wdata_out == ret_q[15:8]
        && stack_pointer_out == sp_q + 8'h02) else $error("call push");
    a_call_target: assert property (tk && op_in == `OP_LONG_CALL
        |-> ##3 pc_out == tgt_q && done_out) else $error("call target");
endmodule // branch_exec_monitor
bind branch_and_pointer_increment_exec branch_exec_monitor i_mon (.*);

// ==== testbench/branch_and_pointer_increment_exec_tb.sv ====
// Purpose: Self-checking bench for the branch execution block
// Assumes: Operand bytes come from the program memory model
// Notes: Integer model predicts pc, pointer, stack and pushes
`timescale 1ns/1ps
`include "branch_exec_defines.vh"
module branch_and_pointer_increment_exec_tb;
    reg clk_in = 1'b0, nrst_in = 1'b0, start_in = 1'b0;
    reg [3:0] op_in = 4'h0;
    reg bv = 1'b0, bp = 1'b0, bl = 1'b0, cy = 1'b0, pl = 1'b0, sl = 1'b0;
    reg [7:0] acc = 8'h00, spv = 8'h00;
    reg [15:0] ptrv = 16'h0000;
    wire [7:0] b2, b3, lo, hi, sp, ra, rd;
    wire [15:0] pc;
    wire busy, done, we, bclr;
    integer num_errors = 0, checked = 0, epc = 0, eptr = 0, esp = 7, i, r;
    reg [15:0] wq[$];
    initial forever #20 clk_in = ~clk_in;
    branch_and_pointer_increment_exec i_dut (.clk_in(clk_in),
        .nrst_in(nrst_in), .start_in(start_in), .op_in(op_in),
        .byte2_in(b2), .byte3_in(b3), .bit_value_in(bv),
        .bit_is_port_in(bp), .port_latch_bit_in(bl), .carry_in(cy),
        .acc_in(acc), .ptr_load_in(pl), .ptr_load_value_in(ptrv),
        .sp_load_in(sl), .sp_load_value_in(spv), .busy_out(busy),
        .done_out(done), .pc_out(pc), .pointer_low_byte_out(lo),
        .pointer_high_byte_out(hi), .stack_pointer_out(sp),
        .ram_we_out(we), .ram_addr_out(ra), .ram_wdata_out(rd),
        .bit_clear_out(bclr));
    prog_mem_model i_m2 (.addr_in(pc + 16'h0001), .data_out(b2));
    prog_mem_model i_m3 (.addr_in(pc + 16'h0002), .data_out(b3));
    always @(posedge clk_in) if (we) wq.push_back({ra, rd});
    task check(input [15:0] seen, input [15:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("errors=%0d checks=%0d", num_errors, checked);
            if (num_errors == 0 && checked > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    // ----------------------------------------
    // Operation model
    // ----------------------------------------
    task issue(input [3:0] op);
        integer tk, d, len, jb;
        begin
            op_in = op;
            start_in = 1'b1;
            len = (op == 2 || op == 3 || op == 7) ? 3 : 2;
            d = (len == 3) ? b3 : b2;
            if (d > 127) d = d - 256;
            jb = (bp && op == `OP_JMP_CLR_BIT) ? bl : bv;
            tk = op == 2 ? bv : op == 3 ? jb : op == 7 ? !bv : op == 4 ? cy
                : op == 5 ? !cy : op == 8 ? acc != 0 : acc == 0;
            if (op == `OP_PTR_INC) begin
                eptr = (eptr + 1) & 65535;
                epc = (epc + 1) & 65535;
            end else if (op == `OP_JMP_INDIRECT) epc = (acc + eptr) & 65535;
            else if (op > 1) epc = (epc + len + (tk ? d : 0)) & 65535;
            @(posedge clk_in);
            #1;
            check(pc, epc);
            check({hi, lo}, eptr);
            check(bclr, op == `OP_JMP_CLR_BIT && tk);
            check(sp, esp);
            check(done, 1);
        end
    endtask
    task call_op;
        begin
            op_in = `OP_LONG_CALL;
            start_in = 1'b1;
            r = epc + 3;
            epc = {b2, b3};
            @(posedge clk_in);
            #1;
            start_in = 1'b0;
            repeat (6) @(posedge clk_in);
            #1;
            check(busy, 0);
            check(pc, epc);
            check(wq.pop_front(), ((esp + 1) & 255) * 256 + (r & 255));
            check(wq.pop_front(), ((esp + 2) & 255) * 256 + ((r >> 8) & 255));
            esp = (esp + 2) & 255;
            check(sp, esp);
            check(wq.size(), 0);
        end
    endtask
    initial begin
        i = $urandom(32'h4dd47b88);
        repeat (3) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        check(pc, 0);
        check(sp, 7);
        ptrv = 16'hfffe;
        pl = 1'b1;
        @(posedge clk_in);
        #1 pl = 1'b0;
        eptr = 16'hfffe;
        issue(`OP_PTR_INC);
        issue(`OP_PTR_INC);
        start_in = 1'b0;
        ptrv = 16'h12f0;
        pl = 1'b1;
        @(posedge clk_in);
        #1 pl = 1'b0;
        eptr = 16'h12f0;
        for (i = 0; i < 80; i = i + 1) begin
            acc = ($urandom % 4 == 0) ? 8'h00 : $urandom;
            {cy, bv, bp, bl} = $urandom;
            issue($urandom % 10);
        end
        start_in = 1'b0;
        spv = 8'h7e;
        sl = 1'b1;
        @(posedge clk_in);
        #1 sl = 1'b0;
        esp = 8'h7e;
        call_op();
        call_op();
        issue(`OP_JMP_ACC_Z);
        start_in = 1'b0;
        conclude();
    end
    initial begin
        #100000;
        num_errors = num_errors + 1;
        conclude();
    end
endmodule // branch_and_pointer_increment_exec_tb
